// ==== hw/ipc_regs.vh ====
// Functional notes
// - dm line polarity normal or invert, present only with async or adpcm fitted.
// - rs and cs lines each get their own polarity choice, async only.
// - mc, tt, rt and st timing lines each invert independently, async only.
// - remote port rate selectable from 110 to 19200 bit/s and readable.
// - remote port parity even, odd or none, applied to port characters.
// - remote address holds 1 to 255 and reads back.
// - operating mode is duplex, receive only or transmit only.
// - one-way modes mask unused direction faults from live and stored reports.
// - lamp test lights every indicator for three seconds, then normal.
// - display contrast steps up or down by one, held within 0 to 100.
// - time of day and date run, read back, and load on a set command.
`ifndef IPC_REGS_VH
`define IPC_REGS_VH

// register byte offsets
`define IPC_POL_EDIT    8'h00
`define IPC_PORT_EDIT   8'h04
`define IPC_ADDR_EDIT   8'h08
`define IPC_MODE_EDIT   8'h0C
`define IPC_TIME_EDIT   8'h10
`define IPC_DATE_EDIT   8'h14
`define IPC_CONFIRM     8'h18
`define IPC_ACTIVE0     8'h1C
`define IPC_ACTIVE1     8'h20
`define IPC_TIME_NOW    8'h24
`define IPC_DATE_NOW    8'h28
`define IPC_IRQ_STAT    8'h2C
`define IPC_IRQ_MASK    8'h30
`define IPC_FLT_STORE   8'h34

// confirm register bit positions
`define IPC_CF_POL      0
`define IPC_CF_PORT     1
`define IPC_CF_ADDR     2
`define IPC_CF_MODE     3
`define IPC_CF_CLOCK    4
`define IPC_CF_LAMP     5
`define IPC_CF_UP       6
`define IPC_CF_DOWN     7

// interrupt status bit positions
`define IPC_EV_APPLIED  0
`define IPC_EV_REJECT   1
`define IPC_EV_LAMP     2
`define IPC_EV_LIMIT    3

// polarity bit positions
`define IPC_POL_DM      0
`define IPC_POL_RS      1
`define IPC_POL_CS      2
`define IPC_POL_MC      3
`define IPC_POL_TT      4
`define IPC_POL_RT      5
`define IPC_POL_ST      6

// modes and parity codes
`define IPC_MODE_DUPLEX 2'h0
`define IPC_MODE_RXONLY 2'h1
`define IPC_MODE_TXONLY 2'h2
`define IPC_PAR_NONE    2'h0
`define IPC_PAR_EVEN    2'h1
`define IPC_PAR_ODD     2'h2

// rate codes 0..7: 110,300,600,1200,2400,4800,9600,19200 bit/s
`define IPC_RATE_MAX    3'h7

// limits and reset values
`define IPC_CONTRAST_MAX 7'h64
`define IPC_CONTRAST_RST 7'h32
`define IPC_ADDR_RST     8'h01
`define IPC_RATE_RST     3'h6
`define IPC_DATE_RST     16'h0021
`define IPC_DAY_RST      5'h01
`define IPC_MON_RST      4'h1

// timing
`define IPC_CLK_HZ       20000000
`define IPC_LAMP_MS      3000
`define IPC_LAMP_CYCLES  ((`IPC_CLK_HZ / 1000) * `IPC_LAMP_MS)
`define IPC_SEC_CYCLES   (`IPC_CLK_HZ)

`endif

// ==== hw/ipc_oneshot.v ====
`timescale 1ns/1ps
module ipc_oneshot #(
   parameter CW  = 26,
   parameter LEN = 60000000
) (
   // clock and reset
   input  wire clk_i,
   input  wire srst_i,
   // control
   input  wire start_i,
   output wire busy_o,
   output reg  done_o
);
   localparam [CW-1:0] LAST = LEN[CW-1:0] - 1'b1;

   reg [CW-1:0] cnt_q;
   reg          busy_q;

   assign busy_o = busy_q;

   // a start while running restarts the full interval
   always @(posedge clk_i) begin
      if (srst_i) begin
         cnt_q  <= {CW{1'b0}};
         busy_q <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (start_i) begin
            cnt_q  <= {CW{1'b0}};
            busy_q <= 1'b1;
         end else if (busy_q) begin
            if (cnt_q == LAST) begin
               busy_q <= 1'b0;
               done_o <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
      end
   end
endmodule

// ==== hw/ipc_cfg_top.v ====
`timescale 1ns/1ps
`include "ipc_regs.vh"
module ipc_cfg_top #(
   parameter ASYNC_FIT   = 1,
   parameter ADPCM_FIT   = 0,
   parameter FLT_W       = 4,
   parameter LAMP_W      = 8,
   parameter LAMP_CYCLES = `IPC_LAMP_CYCLES,
   parameter SEC_CYCLES  = `IPC_SEC_CYCLES
) (
   // clock and reset
   input  wire              clk_i,
   input  wire              srst_i,
   // wishbone slave
   input  wire              wb_cyc_i,
   input  wire              wb_stb_i,
   input  wire              wb_we_i,
   input  wire [7:0]        wb_adr_i,
   input  wire [3:0]        wb_sel_i,
   input  wire [31:0]       wb_dat_i,
   output reg  [31:0]       wb_dat_o,
   output reg               wb_ack_o,
   // interface lines dm,rs,cs,mc,tt,rt,st
   input  wire [6:0]        line_i,
   output wire [6:0]        line_o,
   // remote control port
   input  wire [7:0]        rc_char_i,
   output reg  [2:0]        rc_rate_o,
   output reg  [1:0]        rc_parity_o,
   output reg  [7:0]        rc_addr_o,
   output reg               rc_par_bit_o,
   // operation mode and faults
   output reg  [1:0]        mode_o,
   input  wire [FLT_W-1:0]  tx_flt_i,
   input  wire [FLT_W-1:0]  rx_flt_i,
   output reg  [FLT_W-1:0]  tx_flt_o,
   output reg  [FLT_W-1:0]  rx_flt_o,
   // front panel
   input  wire [LAMP_W-1:0] ind_i,
   output reg  [LAMP_W-1:0] ind_o,
   output reg  [6:0]        contrast_o,
   // interrupt
   output wire              irq_o
);
   // option gating of polarity bits
   localparam [6:0] POL_OK = {{6{ASYNC_FIT != 0}}, (ASYNC_FIT != 0) || (ADPCM_FIT != 0)};

   function [31:0] wmerge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  sel;
      integer      b;
      begin
         for (b = 0; b < 4; b = b + 1) begin
            wmerge[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
         end
      end
   endfunction

   function [4:0] month_days;
      input [3:0] mon;
      input [6:0] yr;
      begin
         case (mon)
            4'h2:    month_days = (yr[1:0] == 2'h0) ? 5'h1D : 5'h1C;
            4'h4:    month_days = 5'h1E;
            4'h6:    month_days = 5'h1E;
            4'h9:    month_days = 5'h1E;
            4'hB:    month_days = 5'h1E;
            default: month_days = 5'h1F;
         endcase
      end
   endfunction

   // bus handshake: ack one cycle after the request, dropped the cycle after
   wire wb_req = wb_cyc_i & wb_stb_i;
   wire wr_go  = wb_req & wb_ack_o & wb_we_i;

   // pending edits and active values
   reg  [6:0]        pol_edit_q, pol_q;
   reg  [4:0]        port_edit_q;
   reg  [7:0]        addr_edit_q;
   reg  [1:0]        mode_edit_q;
   reg  [16:0]       time_edit_q;
   reg  [15:0]       date_edit_q;
   reg  [3:0]        irq_stat_q, irq_mask_q;
   reg  [2*FLT_W-1:0] flt_store_q;
   // clock and calendar
   reg  [5:0]        sec_q, min_q;
   reg  [4:0]        hour_q, day_q;
   reg  [3:0]        mon_q;
   reg  [6:0]        year_q;
   reg  [24:0]       tick_cnt_q;
   // fault synchronisers
   reg  [2*FLT_W-1:0] flt_s1_q, flt_s2_q, flt_s3_q, flt_q;

   localparam [24:0] SEC_LAST = SEC_CYCLES[24:0] - 25'h0000001;

   wire [31:0] wd_pol  = wmerge({25'h0, pol_edit_q}, wb_dat_i, wb_sel_i);
   wire [31:0] wd_port = wmerge({27'h0, port_edit_q}, wb_dat_i, wb_sel_i);
   wire [31:0] wd_addr = wmerge({24'h0, addr_edit_q}, wb_dat_i, wb_sel_i);
   wire [31:0] wd_mode = wmerge({30'h0, mode_edit_q}, wb_dat_i, wb_sel_i);
   wire [31:0] wd_time = wmerge({15'h0, time_edit_q}, wb_dat_i, wb_sel_i);
   wire [31:0] wd_date = wmerge({16'h0, date_edit_q}, wb_dat_i, wb_sel_i);
   wire [31:0] wd_mask = wmerge({28'h0, irq_mask_q}, wb_dat_i, wb_sel_i);

   wire       cf_wr  = wr_go & (wb_adr_i == `IPC_CONFIRM) & wb_sel_i[0];
   wire [7:0] cf     = cf_wr ? wb_dat_i[7:0] : 8'h00;

   // validity of pending values
   wire port_ok  = (port_edit_q[4:3] != 2'h3);
   wire addr_ok  = (addr_edit_q != 8'h00);
   wire mode_ok  = (mode_edit_q != 2'h3);
   wire time_ok  = (time_edit_q[4:0] < 5'h18) && (time_edit_q[10:5] < 6'h3C) &&
                   (time_edit_q[16:11] < 6'h3C);
   wire date_ok  = (date_edit_q[8:5] != 4'h0) && (date_edit_q[8:5] < 4'hD) &&
                   (date_edit_q[4:0] != 5'h00) &&
                   (date_edit_q[4:0] <= month_days(date_edit_q[8:5], date_edit_q[15:9])) &&
                   (date_edit_q[15:9] < 7'h64);

   wire ap_port  = cf[`IPC_CF_PORT]  & port_ok;
   wire ap_addr  = cf[`IPC_CF_ADDR]  & addr_ok;
   wire ap_mode  = cf[`IPC_CF_MODE]  & mode_ok;
   wire ap_clock = cf[`IPC_CF_CLOCK] & time_ok & date_ok;
   wire rejected = (cf[`IPC_CF_PORT] & ~port_ok) | (cf[`IPC_CF_ADDR] & ~addr_ok) |
                   (cf[`IPC_CF_MODE] & ~mode_ok) |
                   (cf[`IPC_CF_CLOCK] & ~(time_ok & date_ok));
   wire applied  = cf[`IPC_CF_POL] | ap_port | ap_addr | ap_mode | ap_clock;

   // lamp timer
   wire lamp_busy;
   wire lamp_done;

   ipc_oneshot #(
      .CW  (26),
      .LEN (LAMP_CYCLES)
   ) u_lamp (
      .clk_i   (clk_i),
      .srst_i  (srst_i),
      .start_i (cf[`IPC_CF_LAMP]),
      .busy_o  (lamp_busy),
      .done_o  (lamp_done)
   );

   // contrast stepping
   wire step_up   = cf[`IPC_CF_UP] & ~cf[`IPC_CF_DOWN];
   wire step_down = cf[`IPC_CF_DOWN] & ~cf[`IPC_CF_UP];
   wire at_limit  = (step_up & (contrast_o == `IPC_CONTRAST_MAX)) |
                    (step_down & (contrast_o == 7'h00));

   wire [3:0] ev = {at_limit, lamp_done, rejected, applied};

   assign irq_o  = |(irq_stat_q & irq_mask_q);

   // polarity applied straight on the line; a register here would skew clocks
   assign line_o = line_i ^ pol_q;

   // software-side registers
   always @(posedge clk_i) begin
      if (srst_i) begin
         pol_edit_q  <= 7'h00;
         port_edit_q <= {`IPC_PAR_NONE, `IPC_RATE_RST};
         addr_edit_q <= `IPC_ADDR_RST;
         mode_edit_q <= `IPC_MODE_DUPLEX;
         time_edit_q <= 17'h00000;
         date_edit_q <= `IPC_DATE_RST;
         irq_mask_q  <= 4'h0;
      end else if (wr_go) begin
         case (wb_adr_i)
            `IPC_POL_EDIT:  pol_edit_q  <= wd_pol[6:0] & POL_OK;
            `IPC_PORT_EDIT: port_edit_q <= wd_port[4:0];
            `IPC_ADDR_EDIT: addr_edit_q <= wd_addr[7:0];
            `IPC_MODE_EDIT: mode_edit_q <= wd_mode[1:0];
            `IPC_TIME_EDIT: time_edit_q <= wd_time[16:0];
            `IPC_DATE_EDIT: date_edit_q <= wd_date[15:0];
            `IPC_IRQ_MASK:  irq_mask_q  <= wd_mask[3:0];
            default: begin
            end
         endcase
      end
   end

   // active settings change only on confirm
   always @(posedge clk_i) begin
      if (srst_i) begin
         pol_q       <= 7'h00;
         rc_rate_o   <= `IPC_RATE_RST;
         rc_parity_o <= `IPC_PAR_NONE;
         rc_addr_o   <= `IPC_ADDR_RST;
         mode_o      <= `IPC_MODE_DUPLEX;
      end else begin
         if (cf[`IPC_CF_POL]) begin
            pol_q <= pol_edit_q & POL_OK;
         end
         if (ap_port) begin
            rc_rate_o   <= port_edit_q[2:0];
            rc_parity_o <= port_edit_q[4:3];
         end
         if (ap_addr) begin
            rc_addr_o <= addr_edit_q;
         end
         if (ap_mode) begin
            mode_o <= mode_edit_q;
         end
      end
   end

   // parity bit, registered from the character on the remote port one cycle earlier
   always @(posedge clk_i) begin
      if (srst_i) begin
         rc_par_bit_o <= 1'b0;
      end else begin
         case (rc_parity_o)
            `IPC_PAR_EVEN: rc_par_bit_o <= ^rc_char_i;
            `IPC_PAR_ODD:  rc_par_bit_o <= ~^rc_char_i;
            default:       rc_par_bit_o <= 1'b0;
         endcase
      end
   end

   // faults: three-stage sync, accept a change once stages two and three agree
   always @(posedge clk_i) begin
      if (srst_i) begin
         flt_s1_q <= {2*FLT_W{1'b0}};
         flt_s2_q <= {2*FLT_W{1'b0}};
         flt_s3_q <= {2*FLT_W{1'b0}};
         flt_q    <= {2*FLT_W{1'b0}};
      end else begin
         flt_s1_q <= {rx_flt_i, tx_flt_i};
         flt_s2_q <= flt_s1_q;
         flt_s3_q <= flt_s2_q;
         flt_q    <= (flt_s2_q & flt_s3_q) | (flt_q & (flt_s2_q | flt_s3_q));
      end
   end

   wire tx_used = (mode_o != `IPC_MODE_RXONLY);
   wire rx_used = (mode_o != `IPC_MODE_TXONLY);
   wire [2*FLT_W-1:0] flt_live = flt_q & {{FLT_W{rx_used}}, {FLT_W{tx_used}}};

   wire st_clr_wr = wr_go & (wb_adr_i == `IPC_FLT_STORE);
   wire is_clr_wr = wr_go & (wb_adr_i == `IPC_IRQ_STAT) & wb_sel_i[0];

   // sticky records: a new event wins over a clear in the same cycle
   always @(posedge clk_i) begin
      if (srst_i) begin
         tx_flt_o    <= {FLT_W{1'b0}};
         rx_flt_o    <= {FLT_W{1'b0}};
         flt_store_q <= {2*FLT_W{1'b0}};
         irq_stat_q  <= 4'h0;
      end else begin
         tx_flt_o    <= flt_live[FLT_W-1:0];
         rx_flt_o    <= flt_live[2*FLT_W-1:FLT_W];
         flt_store_q <= (flt_store_q & ~(st_clr_wr ? wb_dat_i[2*FLT_W-1:0] :
                        {2*FLT_W{1'b0}})) | flt_live;
         irq_stat_q  <= (irq_stat_q & ~(is_clr_wr ? wb_dat_i[3:0] : 4'h0)) | ev;
      end
   end

   // lamp test and contrast
   always @(posedge clk_i) begin
      if (srst_i) begin
         ind_o      <= {LAMP_W{1'b0}};
         contrast_o <= `IPC_CONTRAST_RST;
      end else begin
         ind_o <= lamp_busy ? {LAMP_W{1'b1}} : ind_i;
         if (step_up && contrast_o != `IPC_CONTRAST_MAX) begin
            contrast_o <= contrast_o + 7'h01;
         end else if (step_down && contrast_o != 7'h00) begin
            contrast_o <= contrast_o - 7'h01;
         end
      end
   end

   // running clock and calendar, one tick a second from the divider
   wire sec_tick = (tick_cnt_q == SEC_LAST);
   wire sec_wrap = (sec_q == 6'h3B);
   wire min_wrap = sec_wrap & (min_q == 6'h3B);
   wire hr_wrap  = min_wrap & (hour_q == 5'h17);
   wire day_wrap = hr_wrap & (day_q == month_days(mon_q, year_q));
   wire mon_wrap = day_wrap & (mon_q == 4'hC);

   always @(posedge clk_i) begin
      if (srst_i) begin
         tick_cnt_q <= 25'h0000000;
         sec_q      <= 6'h00;
         min_q      <= 6'h00;
         hour_q     <= 5'h00;
         day_q      <= `IPC_DAY_RST;
         mon_q      <= `IPC_MON_RST;
         year_q     <= 7'h00;
      end else if (ap_clock) begin
         tick_cnt_q <= 25'h0000000;
         hour_q     <= time_edit_q[4:0];
         min_q      <= time_edit_q[10:5];
         sec_q      <= time_edit_q[16:11];
         day_q      <= date_edit_q[4:0];
         mon_q      <= date_edit_q[8:5];
         year_q     <= date_edit_q[15:9];
      end else if (sec_tick) begin
         tick_cnt_q <= 25'h0000000;
         sec_q      <= sec_wrap ? 6'h00 : sec_q + 6'h01;
         if (sec_wrap) begin
            min_q <= (min_q == 6'h3B) ? 6'h00 : min_q + 6'h01;
         end
         if (min_wrap) begin
            hour_q <= (hour_q == 5'h17) ? 5'h00 : hour_q + 5'h01;
         end
         if (hr_wrap) begin
            day_q <= day_wrap ? 5'h01 : day_q + 5'h01;
         end
         if (day_wrap) begin
            mon_q <= mon_wrap ? 4'h1 : mon_q + 4'h1;
         end
         if (mon_wrap) begin
            year_q <= (year_q == 7'h63) ? 7'h00 : year_q + 7'h01;
         end
      end else begin
         tick_cnt_q <= tick_cnt_q + 25'h0000001;
      end
   end

   // read mux; unmapped offsets read zero and are still acknowledged
   reg [31:0] rd_d;
   always @* begin
      case (wb_adr_i)
         `IPC_POL_EDIT:  rd_d = {25'h0, pol_edit_q};
         `IPC_PORT_EDIT: rd_d = {27'h0, port_edit_q};
         `IPC_ADDR_EDIT: rd_d = {24'h0, addr_edit_q};
         `IPC_MODE_EDIT: rd_d = {30'h0, mode_edit_q};
         `IPC_TIME_EDIT: rd_d = {15'h0, time_edit_q};
         `IPC_DATE_EDIT: rd_d = {16'h0, date_edit_q};
         `IPC_ACTIVE0:   rd_d = {7'h0, lamp_busy, 2'h0, mode_o, 2'h0, rc_parity_o,
                                 5'h0, rc_rate_o, 1'b0, pol_q};
         `IPC_ACTIVE1:   rd_d = {17'h0, contrast_o, rc_addr_o};
         `IPC_TIME_NOW:  rd_d = {15'h0, sec_q, min_q, hour_q};
         `IPC_DATE_NOW:  rd_d = {16'h0, year_q, mon_q, day_q};
         `IPC_IRQ_STAT:  rd_d = {28'h0, irq_stat_q};
         `IPC_IRQ_MASK:  rd_d = {28'h0, irq_mask_q};
         `IPC_FLT_STORE: rd_d = {{(32-2*FLT_W){1'b0}}, flt_store_q};
         default:        rd_d = 32'h00000000;
      endcase
   end

   always @(posedge clk_i) begin
      if (srst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_req & ~wb_ack_o;
         wb_dat_o <= (wb_req & ~wb_ack_o & ~wb_we_i) ? rd_d : 32'h00000000;
      end
   end
endmodule

// ==== tb/ipc_cfg_asserts.sv ====
`timescale 1ns/1ps
module ipc_cfg_asserts #(
   parameter FLT_W       = 4,
   parameter LAMP_W      = 8,
   parameter LAMP_CYCLES = 20
) (
   // clock and reset
   input wire              clk_i,
   input wire              srst_i,
   // bus
   input wire              wb_cyc_i,
   input wire              wb_stb_i,
   input wire [31:0]       wb_dat_o,
   input wire              wb_ack_o,
   // lines and remote port
   input wire [6:0]        line_i,
   input wire [6:0]        line_o,
   input wire [7:0]        rc_char_i,
   input wire [1:0]        rc_parity_o,
   input wire [7:0]        rc_addr_o,
   input wire              rc_par_bit_o,
   // mode, faults, panel
   input wire [1:0]        mode_o,
   input wire [FLT_W-1:0]  tx_flt_o,
   input wire [FLT_W-1:0]  rx_flt_o,
   input wire [LAMP_W-1:0] ind_i,
   input wire [LAMP_W-1:0] ind_o,
   input wire [6:0]        contrast_o
);
   default clocking dcb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);
   reg  [LAMP_W-1:0] ind_q;
   reg  [31:0]       run_q;
   // all-ones only counts as lamp time while the delayed input is not all ones
   wire              lamp_on = (&ind_o) && !(&ind_q);
   always @(posedge clk_i) begin
      ind_q <= ind_i;
      if (srst_i || !lamp_on)
         run_q <= 32'h0;
      else
         run_q <= run_q + 32'h1;
   end
   AST_LINE_POL:
   assert property (!wb_ack_o && !$past(wb_ack_o) && !$past(wb_ack_o, 2)
      |-> (line_o ^ line_i) == $past(line_o ^ line_i)) else $error("polarity changed unasked");
   AST_ACK_ONE:
   assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   AST_ACK_WAIT:
   assert property ($rose(wb_cyc_i && wb_stb_i) |-> !wb_ack_o ##1 wb_ack_o)
      else $error("ack not one cycle after request");
   AST_DAT_IDLE:
   assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
   AST_CONTRAST_RANGE:
   assert property (contrast_o <= 7'h64) else $error("contrast above limit");
   AST_CONTRAST_STEP:
   assert property ($changed(contrast_o) |-> contrast_o == $past(contrast_o) + 7'h1
      || contrast_o + 7'h1 == $past(contrast_o)) else $error("contrast jumped");
   AST_ADDR_NZ:
   assert property (rc_addr_o != 8'h00) else $error("address zero");
   AST_MODE_LEGAL:
   assert property (mode_o != 2'h3) else $error("illegal mode");
   AST_PAR_BIT:
   assert property (rc_par_bit_o == ($past(rc_parity_o) == 2'h1 ? ^$past(rc_char_i) :
      $past(rc_parity_o) == 2'h2 ? ~^$past(rc_char_i) : 1'b0)) else $error("parity bit wrong");
   AST_RX_MASK:
   assert property (mode_o == 2'h1 && $past(mode_o) == 2'h1 && $past(mode_o, 2) == 2'h1
      |-> tx_flt_o == 0) else $error("tx fault seen in rx only");
   AST_TX_MASK:
   assert property (mode_o == 2'h2 && $past(mode_o) == 2'h2 && $past(mode_o, 2) == 2'h2
      |-> rx_flt_o == 0) else $error("rx fault seen in tx only");
   AST_IND_FOLLOW:
   assert property (!(&ind_o) && !$past(srst_i) |-> ind_o == $past(ind_i))
      else $error("indicators not following");
   AST_LAMP_LEN:
   assert property ($fell(lamp_on) |-> run_q == LAMP_CYCLES) else $error("lamp time wrong");
   cover property ($rose(lamp_on));
   cover property (mode_o == 2'h1);
   cover property (contrast_o == 7'h64);
endmodule
bind ipc_cfg_top ipc_cfg_asserts #(
   .FLT_W(FLT_W), .LAMP_W(LAMP_W), .LAMP_CYCLES(LAMP_CYCLES)
) u_chk (
   .clk_i(clk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .line_i(line_i), .line_o(line_o),
   .rc_char_i(rc_char_i), .rc_parity_o(rc_parity_o), .rc_addr_o(rc_addr_o),
   .rc_par_bit_o(rc_par_bit_o), .mode_o(mode_o), .tx_flt_o(tx_flt_o),
   .rx_flt_o(rx_flt_o), .ind_i(ind_i), .ind_o(ind_o), .contrast_o(contrast_o)
);

// ==== tb/ipc_dte_model.sv ====
`timescale 1ns/1ps
module ipc_dte_model (
   // clock
   input  wire       clk_i,
   // lines toward the modem
   output reg  [6:0] line_o,
   output reg  [7:0] char_o
);
   // walking pattern: every line sees both levels, so a stuck inversion shows
   initial begin
      line_o = 7'h55;
      char_o = 8'h00;
   end
   always @(posedge clk_i) begin
      line_o <= {line_o[5:0], ~line_o[6]};
      char_o <= char_o + 8'h3B;
   end
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`include "ipc_regs.vh"
module testbench;
   localparam LAMP = 20;
   reg         clk_i = 1'b0;
   reg         srst_i = 1'b1;
   reg         wb_cyc_i = 1'b0;
   reg         wb_stb_i = 1'b0;
   reg         wb_we_i = 1'b0;
   reg  [7:0]  wb_adr_i = 8'h00;
   reg  [3:0]  wb_sel_i = 4'h0;
   reg  [31:0] wb_dat_i = 32'h0;
   reg  [3:0]  tx_flt_i = 4'h0;
   reg  [3:0]  rx_flt_i = 4'h0;
   reg  [7:0]  ind_i = 8'h5A;
   wire [31:0] wb_dat_o;
   wire        wb_ack_o;
   wire [6:0]  line_i;
   wire [6:0]  line_o;
   wire [7:0]  rc_char_i;
   wire [2:0]  rc_rate_o;
   wire [1:0]  rc_parity_o;
   wire [7:0]  rc_addr_o;
   wire        rc_par_bit_o;
   wire [1:0]  mode_o;
   wire [3:0]  tx_flt_o;
   wire [3:0]  rx_flt_o;
   wire [7:0]  ind_o;
   wire [6:0]  contrast_o;
   wire        irq_o;
   reg  [7:0]  char_q;
   reg  [31:0] rd;
   integer     num_errors = 0;
   integer     n_compared = 0;
   integer     i;
   integer     j;
   always #25 clk_i = ~clk_i;
   always @(posedge clk_i) char_q <= rc_char_i;
   ipc_cfg_top #(.LAMP_CYCLES(LAMP), .SEC_CYCLES(10)) i_dut (
      .clk_i(clk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .line_i(line_i), .line_o(line_o),
      .rc_char_i(rc_char_i), .rc_rate_o(rc_rate_o), .rc_parity_o(rc_parity_o),
      .rc_addr_o(rc_addr_o), .rc_par_bit_o(rc_par_bit_o), .mode_o(mode_o),
      .tx_flt_i(tx_flt_i), .rx_flt_i(rx_flt_i), .tx_flt_o(tx_flt_o), .rx_flt_o(rx_flt_o),
      .ind_i(ind_i), .ind_o(ind_o), .contrast_o(contrast_o), .irq_o(irq_o));
   ipc_dte_model i_dte (.clk_i(clk_i), .line_o(line_i), .char_o(rc_char_i));
   task finish_test;
      begin
         $display("compared %0d mismatches %0d", n_compared, num_errors);
         if (num_errors == 0 && n_compared > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // one classic cycle; request held until ack is sampled at an edge
   task wb(input w, input [7:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge clk_i);
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         wb_we_i  <= w;
         wb_adr_i <= a;
         wb_sel_i <= 4'hF;
         wb_dat_i <= d;
         n = 0;
         @(posedge clk_i);
         while (wb_ack_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n = n + 1;
         end
         rd = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
         wb_we_i  <= 1'b0;
         if (n == 20) begin
            num_errors = num_errors + 1;
            $display("[ERR] %0t no bus answer", $time);
            finish_test;
         end
      end
   endtask
   task rchk(input [7:0] a, input [31:0] e);
      begin
         wb(1'b0, a, 32'h0);
         chk(rd, e);
      end
   endtask
   // confirm, then let the apply edge pass before ports are looked at
   task conf(input [7:0] b);
      begin
         wb(1'b1, `IPC_CONFIRM, {24'h0, b});
         @(posedge clk_i);
         @(negedge clk_i);
      end
   endtask
   task done(input [8*8-1:0] s);
      $display("test %0s done", s);
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      srst_i <= 1'b0;
      rchk(`IPC_ACTIVE0, 32'h0000_0600);
      rchk(`IPC_ACTIVE1, 32'h0000_3201);
      rchk(8'hFC, 32'h0);
      done("reset");
      wb(1'b1, `IPC_POL_EDIT, 32'h7F);
      @(negedge clk_i);
      chk(line_o, line_i);
      rchk(`IPC_ACTIVE0, 32'h0000_0600);
      for (i = 0; i < 8; i = i + 1) begin
         wb(1'b1, `IPC_POL_EDIT, i < 7 ? 32'h1 << i : 32'h7F);
         conf(8'h01);
         for (j = 0; j < 3; j = j + 1) begin
            chk(line_o, line_i ^ (i < 7 ? 7'h1 << i : 7'h7F));
            @(negedge clk_i);
         end
      end
      done("polarity");
      for (i = 0; i < 24; i = i + 1) begin
         wb(1'b1, `IPC_PORT_EDIT, i);
         conf(8'h02);
         chk(rc_rate_o, i % 8);
         chk(rc_parity_o, i / 8);
         chk(rc_par_bit_o, i / 8 == 1 ? ^char_q : i / 8 == 2 ? ~^char_q : 0);
      end
      wb(1'b1, `IPC_PORT_EDIT, 32'h18);
      conf(8'h02);
      rchk(`IPC_ACTIVE0, 32'h0002_077F);
      wb(1'b1, `IPC_ADDR_EDIT, 32'h0);
      conf(8'h04);
      chk(rc_addr_o, 32'h1);
      wb(1'b1, `IPC_ADDR_EDIT, 32'hFF);
      conf(8'h04);
      rchk(`IPC_ACTIVE1, 32'h0000_32FF);
      done("port");
      @(posedge clk_i);
      tx_flt_i <= 4'h9;
      rx_flt_i <= 4'h6;
      for (i = 0; i < 3; i = i + 1) begin
         wb(1'b1, `IPC_MODE_EDIT, i);
         conf(8'h08);
         repeat (8) @(negedge clk_i);
         chk(mode_o, i);
         chk(tx_flt_o, i == 1 ? 0 : 9);
         chk(rx_flt_o, i == 2 ? 0 : 6);
      end
      wb(1'b1, `IPC_FLT_STORE, 32'hFF);
      repeat (3) @(negedge clk_i);
      rchk(`IPC_FLT_STORE, 32'h09);
      wb(1'b1, `IPC_MODE_EDIT, 32'h3);
      conf(8'h08);
      chk(mode_o, 2);
      rchk(`IPC_IRQ_STAT, 32'h3);
      done("mode");
      wb(1'b1, `IPC_IRQ_STAT, 32'hF);
      wb(1'b1, `IPC_IRQ_MASK, 32'h4);
      conf(8'h20);
      j = 0;
      while (ind_o !== 8'hFF && j < 50) begin
         @(negedge clk_i);
         j = j + 1;
      end
      j = 0;
      while (ind_o === 8'hFF && j < 100) begin
         @(negedge clk_i);
         j = j + 1;
      end
      chk(j, LAMP);
      chk(ind_o, 8'h5A);
      repeat (2) @(negedge clk_i);
      chk(irq_o, 1);
      wb(1'b1, `IPC_IRQ_MASK, 32'h0);
      @(negedge clk_i);
      chk(irq_o, 0);
      wb(1'b1, `IPC_IRQ_MASK, 32'h4);
      @(negedge clk_i);
      chk(irq_o, 1);
      wb(1'b1, `IPC_IRQ_STAT, 32'h4);
      @(negedge clk_i);
      chk(irq_o, 0);
      done("lamp");
      for (i = 0; i < 52; i = i + 1)
         conf(8'h40);
      chk(contrast_o, 100);
      conf(8'hC0);
      chk(contrast_o, 100);
      for (i = 0; i < 101; i = i + 1)
         conf(8'h80);
      rchk(`IPC_ACTIVE1, 32'h0000_00FF);
      rchk(`IPC_IRQ_STAT, 32'h8);
      done("contrast");
      wb(1'b1, `IPC_TIME_EDIT, (58 << 11) | (59 << 5) | 23);
      wb(1'b1, `IPC_DATE_EDIT, (4 << 9) | (2 << 5) | 28);
      conf(8'h10);
      rchk(`IPC_TIME_NOW, (58 << 11) | (59 << 5) | 23);
      repeat (18) @(posedge clk_i);
      rchk(`IPC_TIME_NOW, 32'h0);
      rchk(`IPC_DATE_NOW, (4 << 9) | (2 << 5) | 29);
      rchk(`IPC_IRQ_STAT, 32'h9);
      done("clock");
      finish_test;
   end
endmodule
